// file: hdl/hcp_defs.vh
// Purpose: constants of the transmit header framer (offsets, fields, reset values)
// Assumes: 8-bit register port with 8-bit addresses
// Notes:   included by hcp_header_framer.v and hcp_crc16.v
`ifndef HCP_DEFS_VH
`define HCP_DEFS_VH

// register offsets
`define HCP_OFS_HDR_CFG      8'h02
`define HCP_OFS_SFD_HIGH     8'hc4
`define HCP_OFS_SFD_LOW      8'hc8
`define HCP_OFS_SERVICE      8'hcc
`define HCP_OFS_LEN_HIGH     8'hd0
`define HCP_OFS_LEN_LOW      8'hd4
`define HCP_OFS_CHECK_HIGH   8'hd8
`define HCP_OFS_CHECK_LOW    8'hdc
`define HCP_OFS_PRE_COUNT    8'he0

// header mode field inside the configuration register
`define HCP_MODE_LSB         0
`define HCP_MODE_MSB         1
`define HCP_MODE_OFF         2'h0
`define HCP_MODE_SFD         2'h1
`define HCP_MODE_SFD_LEN     2'h2
`define HCP_MODE_ALL         2'h3

// header fields as seen by the coverage decode
`define HCP_FLD_SFD          2'h0
`define HCP_FLD_SVC          2'h1
`define HCP_FLD_LEN          2'h2
`define HCP_FLD_CRC          2'h3

// reset values
`define HCP_RST_HDR_CFG      8'h00
`define HCP_RST_SFD          16'h0000
`define HCP_RST_SERVICE      8'h00
`define HCP_RST_LEN          16'h0000
`define HCP_RST_PRE_COUNT    8'h50

// check polynomial and preset
`define HCP_CRC_POLY         16'h1021
`define HCP_CRC_PRESET       16'hffff

// last bit index of each field (bits per field minus one)
`define HCP_LAST_SFD         8'h0f
`define HCP_LAST_SVC         8'h07
`define HCP_LAST_LEN         8'h0f
`define HCP_LAST_CRC         8'h0f

// receive header bit positions
`define HCP_RX_SFD_END       6'h0f
`define HCP_RX_SVC_END       6'h17
`define HCP_RX_LEN_END       6'h27
`define HCP_RX_HDR_END       6'h37

`endif

// file: hdl/hcp_crc16.v
// Purpose: bit-serial 16-bit header check accumulator
// Assumes: one data bit per enabled cycle, first bit first
// Notes:   next value is also exported so the caller can use the final bit at once
`timescale 1ns/1ps
`include "hcp_defs.vh"

module hcp_crc16 (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        init,
  input  wire        en,
  input  wire        dataBit,
  output reg  [15:0] crc_q,
  output reg  [15:0] crc_d
);

  reg feedback;

  always @* begin
    feedback = dataBit ^ crc_q[15];
    crc_d    = crc_q;
    if (init) begin
      crc_d = `HCP_CRC_PRESET;
    end else if (en) begin
      crc_d = {crc_q[14:0], 1'b0} ^ (feedback ? `HCP_CRC_POLY : 16'h0000);
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      crc_q <= `HCP_CRC_PRESET;
    end else if (ce) begin
      crc_q <= crc_d;
    end
  end

endmodule // hcp_crc16

// file: hdl/hcp_header_framer.v
// Purpose: transmit header framer with preamble counter, length, SFD and header check
// Assumes: register port and bit streams synchronous to ref_clk
// Notes:   fields are read from the registers at the start of each field
`timescale 1ns/1ps
`include "hcp_defs.vh"

// Functional notes
// - transmitted length bits 0-7 come from the low-byte register, joined with high byte.
// - a 16-bit header check is computed; bits 8-15 and 0-7 readable as two bytes.
// - header mode bits at address 02 select the covered fields; host sets them first.
// - mode 0 no check, 1 SFD only, 2 SFD and length; receive check follows.
// - an 8-bit preamble counter loads from its register and sets preamble bit count.
// - one 16-bit SFD serves the transmitted header and receive matching.
module hcp_header_framer (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [7:0]  regRdData,
  input  wire        txStart,
  output wire        txBusy,
  output wire        txBitValid,
  input  wire        txBitReady,
  output wire        txBit,
  output reg         txDone,
  input  wire        rxHdrStart,
  input  wire        rxBitValid,
  input  wire        rxBit,
  output reg         rxSfdMatch,
  output reg         rxCheckOk,
  output reg         rxDone,
  output reg  [15:0] rxHeaderCheckValue
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_PRE  = 6'h02;
  localparam [5:0] ST_SFD  = 6'h04;
  localparam [5:0] ST_SVC  = 6'h08;
  localparam [5:0] ST_LEN  = 6'h10;
  localparam [5:0] ST_CRC  = 6'h20;

  // coverage of a header field under a mode
  function covered;
    input [1:0] mode;
    input [1:0] field;
    begin
      case (mode)
        `HCP_MODE_SFD:     covered = (field == `HCP_FLD_SFD);
        `HCP_MODE_SFD_LEN: covered = (field == `HCP_FLD_SFD) || (field == `HCP_FLD_LEN);
        `HCP_MODE_ALL:     covered = (field != `HCP_FLD_CRC);
        default:           covered = 1'b0;
      endcase
    end
  endfunction

  // msb of the check goes out first while the shifter sends lsb first
  function [15:0] reverse16;
    input [15:0] v;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        reverse16[i] = v[15 - i];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0]  hdrCfg_q;
  reg  [15:0] sfd_q;
  reg  [7:0]  service_q;
  reg  [15:0] length_q;
  reg  [7:0]  preCount_q;
  reg  [15:0] txHeaderCheckValue_q;
  wire [1:0]  hdrMode = hdrCfg_q[`HCP_MODE_MSB:`HCP_MODE_LSB];

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hdrCfg_q   <= `HCP_RST_HDR_CFG;
      sfd_q      <= `HCP_RST_SFD;
      service_q  <= `HCP_RST_SERVICE;
      length_q   <= `HCP_RST_LEN;
      preCount_q <= `HCP_RST_PRE_COUNT;
    end else if (ce && regWrEn) begin
      if (regAddr == `HCP_OFS_HDR_CFG) begin
        hdrCfg_q <= regWrData;
      end else if (regAddr == `HCP_OFS_SFD_HIGH) begin
        sfd_q[15:8] <= regWrData;
      end else if (regAddr == `HCP_OFS_SFD_LOW) begin
        sfd_q[7:0] <= regWrData;
      end else if (regAddr == `HCP_OFS_SERVICE) begin
        service_q <= regWrData;
      end else if (regAddr == `HCP_OFS_LEN_HIGH) begin
        length_q[15:8] <= regWrData;
      end else if (regAddr == `HCP_OFS_LEN_LOW) begin
        length_q[7:0] <= regWrData;
      end else if (regAddr == `HCP_OFS_PRE_COUNT) begin
        preCount_q <= regWrData;
      end
    end
  end

  // read data is registered; unmapped offsets read zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (ce && regRdEn) begin
      if (regAddr == `HCP_OFS_HDR_CFG) begin
        regRdData <= hdrCfg_q;
      end else if (regAddr == `HCP_OFS_SFD_HIGH) begin
        regRdData <= sfd_q[15:8];
      end else if (regAddr == `HCP_OFS_SFD_LOW) begin
        regRdData <= sfd_q[7:0];
      end else if (regAddr == `HCP_OFS_SERVICE) begin
        regRdData <= service_q;
      end else if (regAddr == `HCP_OFS_LEN_HIGH) begin
        regRdData <= length_q[15:8];
      end else if (regAddr == `HCP_OFS_LEN_LOW) begin
        regRdData <= length_q[7:0];
      end else if (regAddr == `HCP_OFS_CHECK_HIGH) begin
        regRdData <= txHeaderCheckValue_q[15:8];
      end else if (regAddr == `HCP_OFS_CHECK_LOW) begin
        regRdData <= txHeaderCheckValue_q[7:0];
      end else if (regAddr == `HCP_OFS_PRE_COUNT) begin
        regRdData <= preCount_q;
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  reg  [5:0]  state_q;
  reg  [7:0]  bitCnt_q;
  reg  [15:0] shift_q;
  reg  [1:0]  txField;
  wire        txAccept = txBitValid && txBitReady;
  wire        txLast   = (bitCnt_q == 8'h00);
  wire [15:0] txCrc_q;
  wire [15:0] txCrc_d;

  always @* begin
    case (state_q)
      ST_SVC:  txField = `HCP_FLD_SVC;
      ST_LEN:  txField = `HCP_FLD_LEN;
      ST_SFD:  txField = `HCP_FLD_SFD;
      default: txField = `HCP_FLD_CRC;
    endcase
  end

  assign txBusy     = (state_q != ST_IDLE);
  assign txBitValid = txBusy;
  assign txBit      = shift_q[0];

  hcp_crc16 u_txCrc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .init    ((state_q == ST_IDLE) && txStart),
    .en      (txAccept && covered(hdrMode, txField)),
    .dataBit (shift_q[0]),
    .crc_q   (txCrc_q),
    .crc_d   (txCrc_d)
  );

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q              <= ST_IDLE;
      bitCnt_q             <= 8'h00;
      shift_q              <= 16'hffff;
      txDone               <= 1'b0;
      txHeaderCheckValue_q <= 16'h0000;
    end else if (ce) begin
      txDone <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          shift_q <= 16'hffff;
          if (txStart && (preCount_q != 8'h00)) begin
            state_q  <= ST_PRE;
            bitCnt_q <= preCount_q - 8'h01;
          end else if (txStart) begin
            state_q  <= ST_SFD;
            bitCnt_q <= `HCP_LAST_SFD;
            shift_q  <= sfd_q;
          end
        end
        ST_PRE: begin
          if (txAccept && txLast) begin
            state_q  <= ST_SFD;
            bitCnt_q <= `HCP_LAST_SFD;
            shift_q  <= sfd_q;
          end else if (txAccept) begin
            bitCnt_q <= bitCnt_q - 8'h01;
          end
        end
        ST_SFD: begin
          if (txAccept && txLast) begin
            state_q  <= ST_SVC;
            bitCnt_q <= `HCP_LAST_SVC;
            shift_q  <= {8'h00, service_q};
          end else if (txAccept) begin
            bitCnt_q <= bitCnt_q - 8'h01;
            shift_q  <= {1'b1, shift_q[15:1]};
          end
        end
        ST_SVC: begin
          if (txAccept && txLast) begin
            state_q  <= ST_LEN;
            bitCnt_q <= `HCP_LAST_LEN;
            shift_q  <= length_q;
          end else if (txAccept) begin
            bitCnt_q <= bitCnt_q - 8'h01;
            shift_q  <= {1'b1, shift_q[15:1]};
          end
        end
        ST_LEN: begin
          if (txAccept && txLast && (hdrMode == `HCP_MODE_OFF)) begin
            state_q              <= ST_IDLE;
            shift_q              <= 16'hffff;
            txDone               <= 1'b1;
            txHeaderCheckValue_q <= 16'h0000;
          end else if (txAccept && txLast) begin
            state_q              <= ST_CRC;
            bitCnt_q             <= `HCP_LAST_CRC;
            shift_q              <= reverse16(~txCrc_d);
            txHeaderCheckValue_q <= ~txCrc_d;
          end else if (txAccept) begin
            bitCnt_q <= bitCnt_q - 8'h01;
            shift_q  <= {1'b1, shift_q[15:1]};
          end
        end
        ST_CRC: begin
          if (txAccept && txLast) begin
            state_q <= ST_IDLE;
            shift_q <= 16'hffff;
            txDone  <= 1'b1;
          end else if (txAccept) begin
            bitCnt_q <= bitCnt_q - 8'h01;
            shift_q  <= {1'b1, shift_q[15:1]};
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive header check, same mode and SFD as transmit
  reg         rxActive_q;
  reg  [5:0]  rxIdx_q;
  reg  [15:0] rxShift_q;
  reg  [15:0] rxCrcRecv_q;
  reg  [1:0]  rxField;
  wire [15:0] rxCrc_q;
  wire [15:0] rxCrc_d;
  wire        rxTake   = rxActive_q && rxBitValid;
  wire [15:0] rxWord   = {rxBit, rxShift_q[15:1]};
  wire [15:0] rxCrcNew = {rxCrcRecv_q[14:0], rxBit};

  always @* begin
    if (rxIdx_q <= `HCP_RX_SFD_END) begin
      rxField = `HCP_FLD_SFD;
    end else if (rxIdx_q <= `HCP_RX_SVC_END) begin
      rxField = `HCP_FLD_SVC;
    end else if (rxIdx_q <= `HCP_RX_LEN_END) begin
      rxField = `HCP_FLD_LEN;
    end else begin
      rxField = `HCP_FLD_CRC;
    end
  end

  hcp_crc16 u_rxCrc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .init    (rxHdrStart),
    .en      (rxTake && covered(hdrMode, rxField)),
    .dataBit (rxBit),
    .crc_q   (rxCrc_q),
    .crc_d   (rxCrc_d)
  );

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxActive_q         <= 1'b0;
      rxIdx_q            <= 6'h00;
      rxShift_q          <= 16'h0000;
      rxCrcRecv_q        <= 16'h0000;
      rxSfdMatch         <= 1'b0;
      rxCheckOk          <= 1'b0;
      rxDone             <= 1'b0;
      rxHeaderCheckValue <= 16'h0000;
    end else if (ce) begin
      rxDone <= 1'b0;
      if (rxHdrStart) begin
        rxActive_q <= 1'b1;
        rxIdx_q    <= 6'h00;
        rxSfdMatch <= 1'b0;
      end else if (rxTake) begin
        rxShift_q <= rxWord;
        rxIdx_q   <= rxIdx_q + 6'h01;
        if (rxIdx_q == `HCP_RX_SFD_END) begin
          rxSfdMatch <= (rxWord == sfd_q);
        end
        if (rxField == `HCP_FLD_CRC) begin
          rxCrcRecv_q <= rxCrcNew;
        end
        if (rxIdx_q == `HCP_RX_HDR_END) begin
          rxActive_q         <= 1'b0;
          rxDone             <= 1'b1;
          rxHeaderCheckValue <= rxCrcNew;
          // mode 0 carries no check to compare against
          rxCheckOk <= (hdrMode == `HCP_MODE_OFF) || (rxCrcNew == ~rxCrc_q);
        end
      end
    end
  end

endmodule // hcp_header_framer

// file: dv/hcp_framer_monitor.sv
// Purpose: port checker for hcp_header_framer
// Assumes: ce high in the cycles that a relation spans
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module hcp_framer_monitor (
  input wire       ref_clk,
  input wire       rst,
  input wire       ce,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrEn,
  input wire       regRdEn,
  input wire [7:0] regRdData,
  input wire       txStart,
  input wire       txBusy,
  input wire       txBitValid,
  input wire       txBitReady,
  input wire       txBit,
  input wire       txDone,
  input wire       rxHdrStart,
  input wire       rxSfdMatch
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_len_back;
    ce && regWrEn && regAddr == 8'hd4 ##1 !regWrEn ##1 ce && regRdEn && regAddr == 8'hd4
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_len_back: assert property (p_len_back) else $error("length low byte not read back");
  property p_pre_back;
    ce && regWrEn && regAddr == 8'he0 ##1 !regWrEn ##1 ce && regRdEn && regAddr == 8'he0
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_pre_back: assert property (p_pre_back) else $error("preamble count not read back");
  property p_unmapped;
    ce && regRdEn && regAddr == 8'h10 |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !$past(ce && regRdEn) |-> $stable(regRdData);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_start;
    ce && txStart && !txBusy |=> txBitValid && txBusy;
  endproperty
  a_start: assert property (p_start) else $error("frame did not start");
  property p_stand;
    ce && txBitValid && !txBitReady |=> $stable(txBit) && txBitValid;
  endproperty
  a_stand: assert property (p_stand) else $error("bit dropped while stalled");
  property p_done;
    txDone |-> (!txBitValid && $past(txBitValid && txBitReady)) ##1 !txDone;
  endproperty
  a_done: assert property (p_done) else $error("done pulse misplaced");
  property p_rx_clear;
    ce && rxHdrStart |=> !rxSfdMatch;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("delimiter match not cleared");
endmodule // hcp_framer_monitor

bind hcp_header_framer hcp_framer_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .ce(ce), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .txStart(txStart),
  .txBusy(txBusy), .txBitValid(txBitValid), .txBitReady(txBitReady), .txBit(txBit), .txDone(txDone),
  .rxHdrStart(rxHdrStart), .rxSfdMatch(rxSfdMatch));

// file: dv/hcp_bit_sink.sv
// Purpose: modulator-side sink for the transmit bit stream
// Assumes: valid/ready handshake on ref_clk
// Notes:   slow halves the accept rate so the framer must hold its bit
`timescale 1ns/1ps
module hcp_bit_sink (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         slow,
  input  wire         txStart,
  input  wire         txBusy,
  input  wire         txBitValid,
  input  wire         txBit,
  output reg          txBitReady,
  output reg  [255:0] bits_q,
  output reg  [8:0]   cnt_q
);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txBitReady <= 1'h0;
      bits_q <= 256'h0;
      cnt_q <= 9'h000;
    end else begin
      txBitReady <= #1 (slow ? ~txBitReady : 1'h1);
      // clear only on an accepted start, so a refused one shows up
      if (txStart && !txBusy) begin
        bits_q <= 256'h0;
        cnt_q <= 9'h000;
      end else if (txBitValid && txBitReady) begin
        bits_q[cnt_q] <= txBit;
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end
endmodule // hcp_bit_sink

// file: dv/hcp_header_framer_tb.sv
// Purpose: self-checking bench for hcp_header_framer
// Assumes: ce held high except for the final ce-low write; bit sink model on the transmit side
// Notes:   table rows walk every check mode, then reset cases
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  testsRun = testsRun + 1; \
  if ((got) !== (ex)) begin \
    nFail = nFail + 1; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); \
  end \
end
module hcp_header_framer_tb;
  typedef struct packed {
    logic [1:0]  mode;
    logic [7:0]  pre;
    logic [15:0] sfd;
    logic [7:0]  svc;
    logic [15:0] len;
    logic        slow;
  } hcp_row_t;
  reg         ref_clk = 1'h0, rst = 1'h1, ce = 1'h1, regWrEn = 1'h0, regRdEn = 1'h0, txStart = 1'h0;
  reg         rxHdrStart = 1'h0, rxBitValid = 1'h0, rxBit = 1'h0, slow = 1'h0;
  reg [7:0]   regAddr = 8'h00, regWrData = 8'h00, rdVal;
  wire [7:0]  regRdData;
  wire        txBusy, txBitValid, txBitReady, txBit, txDone, rxSfdMatch, rxCheckOk, rxDone;
  wire [15:0] rxHeaderCheckValue;
  wire [255:0] gotBits;
  wire [8:0]  gotCnt;
  reg [255:0] expBits;
  reg [15:0]  crcAcc, expCheck;
  integer     expCnt, hdrIdx, i, k, nFail = 0, testsRun = 0;
  hcp_row_t   rows [4];
  hcp_row_t   r;
  always #2.5 ref_clk = ~ref_clk;
  hcp_header_framer dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .txStart(txStart), .txBusy(txBusy),
    .txBitValid(txBitValid), .txBitReady(txBitReady), .txBit(txBit), .txDone(txDone),
    .rxHdrStart(rxHdrStart), .rxBitValid(rxBitValid), .rxBit(rxBit), .rxSfdMatch(rxSfdMatch),
    .rxCheckOk(rxCheckOk), .rxDone(rxDone), .rxHeaderCheckValue(rxHeaderCheckValue));
  hcp_bit_sink u_sink (.ref_clk(ref_clk), .rst(rst), .slow(slow), .txStart(txStart), .txBusy(txBusy),
    .txBitValid(txBitValid), .txBit(txBit), .txBitReady(txBitReady), .bits_q(gotBits), .cnt_q(gotCnt));
  ////////////////////////////////////////
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk) #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    @(posedge ref_clk) #1;
    regWrEn = 1'h0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge ref_clk) #1;
    regAddr = a;
    regRdEn = 1'h1;
    @(posedge ref_clk) #1;
    regRdEn = 1'h0;
    rdVal = regRdData;
  endtask
  // serial check in transmit order, first bit into the top of the register
  task automatic put(input logic b, input logic cov);
    expBits[expCnt] = b;
    expCnt = expCnt + 1;
    if (cov) crcAcc = {crcAcc[14:0], 1'h0} ^ ((crcAcc[15] ^ b) ? 16'h1021 : 16'h0000);
  endtask
  task automatic sendRx;
    integer j;
    @(posedge ref_clk) #1;
    rxHdrStart = 1'h1;
    @(posedge ref_clk) #1;
    rxHdrStart = 1'h0;
    rxBitValid = 1'h1;
    for (j = 0; j < 56; j++) begin
      rxBit = expBits[hdrIdx + j];
      @(posedge ref_clk) #1;
    end
    rxBitValid = 1'h0;
  endtask
  task reportAndStop;
    $display("checks %0d failures %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #200000;
    nFail = nFail + 1;
    reportAndStop;
  end
  initial begin
    rows[0] = {2'h0, 8'h00, 16'hf3a0, 8'h00, 16'h0001, 1'h0};
    rows[1] = {2'h1, 8'h03, 16'hf3a0, 8'h00, 16'h00ff, 1'h1};
    rows[2] = {2'h2, 8'h50, 16'h1234, 8'h00, 16'h8001, 1'h0};
    rows[3] = {2'h3, 8'h80, 16'hffff, 8'h5a, 16'h7ffe, 1'h1};
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    for (k = 0; k < 4; k++) begin
      r = rows[k];
      slow = r.slow;
      wr(8'h02, {6'h00, r.mode});
      wr(8'hc4, r.sfd[15:8]);
      wr(8'hc8, r.sfd[7:0]);
      wr(8'hcc, r.svc);
      wr(8'hd0, r.len[15:8]);
      wr(8'he0, r.pre);
      wr(8'hd4, r.len[7:0]);
      rd(8'hd4);
      `CHK("len low", r.len[7:0], rdVal)
      expBits = 256'h0;
      expCnt = 0;
      crcAcc = 16'hffff;
      for (i = 0; i < r.pre; i++) put(1'h1, 1'h0);
      hdrIdx = expCnt;
      for (i = 0; i < 16; i++) put(r.sfd[i], r.mode != 2'h0);
      for (i = 0; i < 8; i++) put(r.svc[i], r.mode == 2'h3);
      for (i = 0; i < 16; i++) put(r.len[i], r.mode[1]);
      expCheck = (r.mode == 2'h0) ? 16'h0000 : ~crcAcc;
      for (i = 15; i >= 0 && r.mode != 2'h0; i--) put(expCheck[i], 1'h0);
      @(posedge ref_clk) #1;
      txStart = 1'h1;
      @(posedge ref_clk) #1;
      txStart = 1'h0;
      `CHK("busy", 1'h1, txBusy)
      @(posedge ref_clk) #1;
      txStart = 1'h1;
      @(posedge ref_clk) #1;
      txStart = 1'h0;
      for (i = 0; i < 1000 && txDone !== 1'h1; i++) @(posedge ref_clk) #1;
      `CHK("done", 1'h1, txDone)
      `CHK("count", expCnt[8:0], gotCnt)
      `CHK("bits", expBits, gotBits)
      wr(8'hd8, ~expCheck[15:8]);
      rd(8'hd8);
      `CHK("check hi", expCheck[15:8], rdVal)
      rd(8'hdc);
      `CHK("check lo", expCheck[7:0], rdVal)
      rd(8'he0);
      `CHK("preamble", r.pre, rdVal)
      sendRx;
      `CHK("rx done", 1'h1, rxDone)
      `CHK("rx sfd", 1'h1, rxSfdMatch)
      `CHK("rx ok", 1'h1, rxCheckOk)
      `CHK("rx value", expCheck, rxHeaderCheckValue)
    end
    expBits[hdrIdx] = ~expBits[hdrIdx];
    sendRx;
    `CHK("bad sfd", 1'h0, rxSfdMatch)
    `CHK("bad ok", 1'h0, rxCheckOk)
    @(posedge ref_clk) #1;
    rst = 1'h1;
    @(posedge ref_clk) #1;
    rst = 1'h0;
    `CHK("idle bit", 1'h1, txBit)
    `CHK("busy rst", 1'h0, txBusy)
    `CHK("rx value rst", 16'h0000, rxHeaderCheckValue)
    rd(8'hd4);
    `CHK("len rst", 8'h00, rdVal)
    rd(8'h02);
    `CHK("cfg rst", 8'h00, rdVal)
    rd(8'he0);
    `CHK("pre rst", 8'h50, rdVal)
    rd(8'hd8);
    `CHK("check rst", 8'h00, rdVal)
    rd(8'h10);
    `CHK("unmapped", 8'h00, rdVal)
    wr(8'he0, 8'h80);
    rd(8'he0);
    `CHK("pre dual", 8'h80, rdVal)
    // a write while the clock enable is low must not land
    ce = 1'h0;
    wr(8'he0, 8'h11);
    ce = 1'h1;
    rd(8'he0);
    `CHK("ce hold", 8'h80, rdVal)
    reportAndStop;
  end
endmodule // hcp_header_framer_tb
